// *** core/lcd_timing_consts.svh ***
// Register map, field positions and reset values of the LCD pixel block.
// Assumes a word-aligned register port with an 8-bit byte address.
`ifndef LCD_TIMING_CONSTS_SVH
`define LCD_TIMING_CONSTS_SVH

`define OFS_CTRL      8'h00
`define OFS_SIZE      8'h04
`define OFS_HTIME     8'h08
`define OFS_VTIME     8'h0C
`define OFS_ACB       8'h10
`define OFS_UPPER     8'h14
`define OFS_LOWER     8'h18
`define OFS_STATUS    8'h1C

`define CTRL_EN       0
`define CTRL_TFT      1
`define CTRL_SCAN     3:2
`define CTRL_STNFMT   6:4
`define CTRL_TFTBPP   9:7
`define CTRL_PACK24   10
`define CTRL_BSWAP    11
`define CTRL_HWSWAP   12
`define CTRL_ACBFRM   13
`define CTRL_CDIV     25:16

`define SIZE_H        10:0
`define SIZE_V        25:16
`define T_BACK        7:0
`define T_FRONT       15:8
`define T_SYNC        23:16
`define ACB_CNT       7:0
`define STAT_UNDER    20

`define MASK_CTRL     32'h03FF_3FFF
`define MASK_SIZE     32'h03FF_07FF
`define MASK_TIME     32'h00FF_FFFF
`define MASK_ACB      32'h0000_00FF
`define MASK_ADDR     32'hFFFF_FFFC

`define RST_REG       32'h0000_0000
`define WORD_BYTES    32'h0000_0004
`define WORD_BITS     7'h20

`endif

// *** core/lcd_timing_pkg.sv ***
// Types shared by the LCD pixel format and timing block.
// Assumes the constants header is compiled alongside.
package lcd_timing_pkg;

  typedef enum logic [1:0] {
    PH_SYNC  = 2'b00,
    PH_BACK  = 2'b01,
    PH_ACT   = 2'b10,
    PH_FRONT = 2'b11
  } phase_t;

  typedef enum logic [1:0] {
    SCAN_DUAL4   = 2'b00,
    SCAN_SINGLE4 = 2'b01,
    SCAN_SINGLE8 = 2'b10
  } scan_t;

  typedef enum logic [2:0] {
    FMT_MONO    = 3'b000,
    FMT_GRAY4   = 3'b001,
    FMT_GRAY16  = 3'b010,
    FMT_COL256  = 3'b011,
    FMT_COL4096 = 3'b100
  } stn_fmt_t;

  typedef enum logic [2:0] {
    BPP1  = 3'b000,
    BPP2  = 3'b001,
    BPP4  = 3'b010,
    BPP8  = 3'b011,
    BPP16 = 3'b100,
    BPP24 = 3'b101
  } tft_bpp_t;

  typedef struct packed {
    logic [31:0]             ctrl;
    logic [31:0]             size;
    logic [31:0]             htime;
    logic [31:0]             vtime;
    logic [31:0]             acb;
    logic [31:0]             upper;
    logic [31:0]             lower;
    logic                    under;
    logic [31:0]             rdata;
    logic [9:0]              div;
    logic                    pclk;
    logic [9:0]              phold;
    phase_t                  hph;
    logic [15:0]             hcnt;
    phase_t                  vph;
    logic [15:0]             vcnt;
    logic [7:0]              acb_cnt;
    logic                    acb_lvl;
    logic [1:0][1:0][31:0]   win;
    logic [1:0][1:0]         nval;
    logic [1:0][6:0]         cur;
    logic [1:0][31:0]        ptr;
    logic                    req;
    logic                    req_s;
    logic                    drop;
    logic [31:0]             addr;
    logic [23:0]             vd;
    logic                    vs;
    logic                    hs;
    logic                    lp;
    logic                    de;
    logic                    le;
  } state_t;

endpackage : lcd_timing_pkg

// *** core/lcd_pixel_format_timing.sv ***
// LCD pixel unpacking and panel timing for STN and TFT panels.
// Assumes a same-clock word memory port and a same-clock register port.
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

module lcd_pixel_format_timing
  import lcd_timing_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // Register port.
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  // Frame buffer word port.
  output logic             mem_req_out,
  output logic      [31:0] mem_addr_out,
  input  wire logic        mem_ack_in,
  input  wire logic [31:0] mem_data_in,
  // Panel pins.
  output logic      [23:0] video_data_out,
  output logic             pixel_clock_out,
  output logic             vsync_out,
  output logic             hsync_out,
  output logic             line_pulse_out,
  output logic             data_enable_out,
  output logic             line_end_pulse_out,
  output logic             ac_bias_toggle_out
);

`include "lcd_timing_consts.svh"

  function automatic logic [31:0] swap_word(input logic [31:0] w,
                                            input logic bs,
                                            input logic hw);
    logic [31:0] t;
    t = bs ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
    return hw ? {t[15:0], t[31:16]} : t;
  endfunction : swap_word

  // Turns a memory word into the bit stream for the STN driver, first bit
  // at the top. Gray and colour levels keep only their top bit here, since
  // frame rate control lives outside this block.
  function automatic logic [31:0] stn_bits(input logic [31:0] w,
                                           input stn_fmt_t f);
    logic [31:0] b;
    b = 32'h0000_0000;
    case (f)
      FMT_MONO: b = w;
      FMT_GRAY4: begin
        for (int i = 0; i < 16; i++) b[31-i] = w[31-2*i];
      end
      FMT_GRAY16, FMT_COL4096: begin
        for (int i = 0; i < 8; i++) b[31-i] = w[31-4*i];
      end
      FMT_COL256: begin
        for (int i = 0; i < 4; i++) begin
          b[31-3*i] = w[31-8*i];
          b[30-3*i] = w[28-8*i];
          b[29-3*i] = w[25-8*i];
        end
      end
      default: b = w;
    endcase
    return b;
  endfunction : stn_bits

  function automatic logic [6:0] stn_per_word(input stn_fmt_t f);
    case (f)
      FMT_GRAY4:   return 7'h10;
      FMT_GRAY16:  return 7'h08;
      FMT_COL256:  return 7'h0C;
      FMT_COL4096: return 7'h08;
      default:     return `WORD_BITS;
    endcase
  endfunction : stn_per_word

  function automatic logic [6:0] tft_step(input tft_bpp_t p);
    case (p)
      BPP1:    return 7'h01;
      BPP2:    return 7'h02;
      BPP4:    return 7'h04;
      BPP8:    return 7'h08;
      BPP16:   return 7'h10;
      default: return `WORD_BITS;
    endcase
  endfunction : tft_step

  // Raw is the current pixel aligned to bit 31. Indexed depths hand the
  // index to the palette on the low byte.
  function automatic logic [23:0] tft_pixel(input logic [31:0] raw,
                                            input tft_bpp_t p,
                                            input logic pack);
    case (p)
      BPP1:    return {23'h00_0000, raw[31]};
      BPP2:    return {22'h00_0000, raw[31:30]};
      BPP4:    return {20'h0_0000, raw[31:28]};
      BPP8:    return {16'h0000, raw[31:24]};
      BPP16:   return {raw[31:27], 3'h0, raw[26:21], 2'h0,
                       raw[20:16], 3'h0};
      default: return pack ? raw[31:8] : raw[23:0];
    endcase
  endfunction : tft_pixel

  function automatic logic [15:0] ph_last(input phase_t p,
                                          input logic [31:0] t,
                                          input logic [15:0] act);
    unique case (p)
      PH_SYNC:  return {8'h00, t[`T_SYNC]};
      PH_BACK:  return {8'h00, t[`T_BACK]};
      PH_ACT:   return act;
      PH_FRONT: return {8'h00, t[`T_FRONT]};
    endcase
  endfunction : ph_last

  state_t          s_r;
  state_t          n;
  logic            en;
  logic            tft;
  scan_t           scan;
  stn_fmt_t        fmt;
  tft_bpp_t        bpp;
  logic [9:0]      cdiv;
  logic            dual;
  logic            wide8;
  logic            color;
  logic [15:0]     npix;
  logic [15:0]     nbits;
  logic [15:0]     hact;
  logic [15:0]     nlines;
  logic [15:0]     vact;
  logic [6:0]      step;
  logic [6:0]      perw;
  logic            tick;
  logic            hlast;
  logic            vlast;
  logic            line_wrap;
  logic            frame_wrap;
  logic            restart;
  logic            act_slot;
  logic            under_ev;
  logic [6:0]      c;
  logic [1:0][63:0] take;

  assign en     = s_r.ctrl[`CTRL_EN];
  assign tft    = s_r.ctrl[`CTRL_TFT];
  assign scan   = scan_t'(s_r.ctrl[`CTRL_SCAN]);
  assign fmt    = stn_fmt_t'(s_r.ctrl[`CTRL_STNFMT]);
  assign bpp    = tft_bpp_t'(s_r.ctrl[`CTRL_TFTBPP]);
  assign cdiv   = s_r.ctrl[`CTRL_CDIV];
  assign dual   = !tft && scan == SCAN_DUAL4;
  assign wide8  = s_r.ctrl[3];
  assign color  = fmt == FMT_COL256 || fmt == FMT_COL4096;
  assign npix   = {5'h00, s_r.size[`SIZE_H]} + 16'h0001;
  assign nbits  = color ? npix + {npix[14:0], 1'b0} : npix;
  assign hact   = tft ? npix - 16'h0001
                : (wide8 ? nbits >> 3 : nbits >> 2) - 16'h0001;
  assign nlines = {6'h00, s_r.size[`SIZE_V]} + 16'h0001;
  assign vact   = (dual ? nlines >> 1 : nlines) - 16'h0001;
  assign step   = tft ? tft_step(bpp) : (wide8 ? 7'h08 : 7'h04);
  assign perw   = tft ? `WORD_BITS : stn_per_word(fmt);
  // Slot edge: pixel clock is about to fall, so data settles before rise.
  assign tick   = en && s_r.pclk && s_r.div >= cdiv;
  assign hlast  = s_r.hcnt == ph_last(s_r.hph, s_r.htime, hact);
  assign vlast  = s_r.vcnt == ph_last(s_r.vph, s_r.vtime, vact);
  assign line_wrap  = tick && hlast && s_r.hph == PH_FRONT;
  assign frame_wrap = line_wrap && vlast && s_r.vph == PH_FRONT;
  assign restart    = !en || frame_wrap;

  // Two words per stream form a window so a shift may straddle a word.
  for (genvar g = 0; g < 2; g++) begin : g_win
    logic [31:0] pb0;
    logic [31:0] pb1;
    logic [63:0] wnd;
    logic [31:0] w0;
    logic [31:0] w1;
    assign w0   = swap_word(s_r.win[g][0], s_r.ctrl[`CTRL_BSWAP],
                            s_r.ctrl[`CTRL_HWSWAP]);
    assign w1   = swap_word(s_r.win[g][1], s_r.ctrl[`CTRL_BSWAP],
                            s_r.ctrl[`CTRL_HWSWAP]);
    assign pb0  = tft ? w0 : stn_bits(w0, fmt);
    assign pb1  = tft ? w1 : stn_bits(w1, fmt);
    assign wnd  = {pb0, 32'h0000_0000} | ({pb1, 32'h0000_0000} >> perw);
    assign take[g] = wnd << s_r.cur[g];
  end

  always_comb begin
    n        = s_r;
    n.rdata  = 32'h0000_0000;
    under_ev = 1'b0;
    act_slot = 1'b0;
    c        = 7'h00;
    if (reg_wr_in) begin
      case (reg_addr_in)
        `OFS_CTRL:   n.ctrl  = reg_wdata_in & `MASK_CTRL;
        `OFS_SIZE:   n.size  = reg_wdata_in & `MASK_SIZE;
        `OFS_HTIME:  n.htime = reg_wdata_in & `MASK_TIME;
        `OFS_VTIME:  n.vtime = reg_wdata_in & `MASK_TIME;
        `OFS_ACB:    n.acb   = reg_wdata_in & `MASK_ACB;
        `OFS_UPPER:  n.upper = reg_wdata_in & `MASK_ADDR;
        `OFS_LOWER:  n.lower = reg_wdata_in & `MASK_ADDR;
        `OFS_STATUS: if (reg_wdata_in[`STAT_UNDER]) n.under = 1'b0;
        default: ;
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        `OFS_CTRL:   n.rdata = s_r.ctrl;
        `OFS_SIZE:   n.rdata = s_r.size;
        `OFS_HTIME:  n.rdata = s_r.htime;
        `OFS_VTIME:  n.rdata = s_r.vtime;
        `OFS_ACB:    n.rdata = s_r.acb;
        `OFS_UPPER:  n.rdata = s_r.upper;
        `OFS_LOWER:  n.rdata = s_r.lower;
        `OFS_STATUS: n.rdata = {11'h000, s_r.under, s_r.vph, s_r.hph,
                                6'h00, s_r.vcnt[9:0]};
        default:     n.rdata = 32'h0000_0000;
      endcase
    end
    // Half period of cdiv+1 clocks gives the divide by 2*(cdiv+1).
    if (!en) begin
      n.div = 10'h000;
      n.pclk = 1'b0;
    end else if (s_r.div >= cdiv) begin
      n.div = 10'h000;
      n.pclk = !s_r.pclk;
    end else begin
      n.div = s_r.div + 10'h001;
    end
    n.phold = (!en || n.pclk != s_r.pclk) ? 10'h000 : s_r.phold + 10'h001;
    if (!en) begin
      // Park in the last front porch slot, so the first slot after enable
      // opens a whole frame with vertical sync plus a line pulse (STN) or horizontal sync (TFT).
      n.hph = PH_FRONT;
      n.vph = PH_FRONT;
      n.hcnt = {8'h00, s_r.htime[`T_FRONT]};
      n.vcnt = {8'h00, s_r.vtime[`T_FRONT]};
      n.vd = 24'h00_0000;
      {n.vs, n.hs, n.lp, n.de, n.le} = 5'h00;
      n.acb_lvl = 1'b0;
      n.acb_cnt = 8'h00;
    end else if (tick) begin
      n.hcnt = hlast ? 16'h0000 : s_r.hcnt + 16'h0001;
      if (hlast) n.hph = phase_t'(s_r.hph + 2'h1);
      if (line_wrap) begin
        n.vcnt = vlast ? 16'h0000 : s_r.vcnt + 16'h0001;
        if (vlast) n.vph = phase_t'(s_r.vph + 2'h1);
      end
      act_slot = n.hph == PH_ACT && n.vph == PH_ACT;
      n.vs = n.vph == PH_SYNC;
      n.hs = tft && n.hph == PH_SYNC;
      n.lp = !tft && n.hph == PH_SYNC;
      n.de = tft && act_slot;
      n.le = tft && s_r.hph == PH_ACT && hlast;
      if (!act_slot) n.vd = 24'h00_0000;
      else if (tft) n.vd = tft_pixel(take[0][63:32], bpp,
                                     s_r.ctrl[`CTRL_PACK24]);
      else if (dual) n.vd = {16'h0000, take[0][63:60],
                             take[1][63:60]};
      else if (wide8) n.vd = {16'h0000, take[0][63:56]};
      else n.vd = {20'h0_0000, take[0][63:60]};
      if (tft) begin
        n.acb_lvl = 1'b0;
      end else if (s_r.ctrl[`CTRL_ACBFRM]) begin
        if (frame_wrap) n.acb_lvl = !s_r.acb_lvl;
      end else if (line_wrap) begin
        n.acb_cnt = s_r.acb_cnt + 8'h01;
        if (n.acb_cnt >= s_r.acb[`ACB_CNT]) begin
          n.acb_cnt = 8'h00;
          n.acb_lvl = !s_r.acb_lvl;
        end
      end
    end
    // Consume the window; a slot with no word counts as an underrun.
    for (int g = 0; g < 2; g++) begin
      if (act_slot && (g == 0 || dual)) begin
        if (s_r.nval[g] == 2'h0) under_ev = 1'b1;
        c = s_r.cur[g] + step;
        if (c >= perw) begin
          c = c - perw;
          n.win[g][0] = s_r.win[g][1];
          if (s_r.nval[g] != 2'h0) n.nval[g] = s_r.nval[g] - 2'h1;
        end
        n.cur[g] = c;
      end
    end
    if (under_ev) n.under = 1'b1;
    if (s_r.req && mem_ack_in) begin
      n.req = 1'b0;
      n.drop = 1'b0;
      if (!s_r.drop && !restart) begin
        n.win[s_r.req_s][n.nval[s_r.req_s][0]] = mem_data_in;
        n.nval[s_r.req_s] = n.nval[s_r.req_s] + 2'h1;
        n.ptr[s_r.req_s] = s_r.ptr[s_r.req_s] + `WORD_BYTES;
      end
    end
    // A word in flight at frame start is still taken, then thrown away.
    if (restart) begin
      n.nval = '0;
      n.cur = '0;
      n.ptr[0] = s_r.upper;
      n.ptr[1] = s_r.lower;
      if (s_r.req && !mem_ack_in) n.drop = 1'b1;
    end else if (!n.req) begin
      if (n.nval[0] != 2'h2) begin
        n.req = 1'b1;
        n.req_s = 1'b0;
        n.addr = n.ptr[0];
      end else if (dual && n.nval[1] != 2'h2) begin
        n.req = 1'b1;
        n.req_s = 1'b1;
        n.addr = n.ptr[1];
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) s_r <= '0;
    else s_r <= n;
  end

  assign reg_rdata_out      = s_r.rdata;
  assign mem_req_out        = s_r.req;
  assign mem_addr_out       = s_r.addr;
  assign video_data_out     = s_r.vd;
  assign pixel_clock_out    = s_r.pclk;
  assign vsync_out          = s_r.vs;
  assign hsync_out          = s_r.hs;
  assign line_pulse_out     = s_r.lp;
  assign data_enable_out    = s_r.de;
  assign line_end_pulse_out = s_r.le;
  assign ac_bias_toggle_out = s_r.acb_lvl;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  sequence frame_start;
    $rose(vsync_out);
  endsequence

  four_bit_upper_a: assert property (
    !tft && scan == SCAN_SINGLE4 && $stable(s_r.ctrl)
    |-> video_data_out[7:4] == 4'h0)
    else $error("upper data bits driven in 4-bit single scan");
  disabled_quiet_a: assert property (
    !en |=> video_data_out == 24'h00_0000 && !pixel_clock_out
    && !vsync_out && !hsync_out && !line_pulse_out
    && !data_enable_out && !ac_bias_toggle_out)
    else $error("panel output active while disabled");
  pclk_period_a: assert property (
    $changed(pixel_clock_out) && en && $past(en) && $stable(s_r.ctrl)
    |-> $past(s_r.phold) == cdiv)
    else $error("pixel clock half period wrong");
  line_pulse_a: assert property (
    $rose(line_pulse_out)
    |-> s_r.hph == PH_SYNC && $past(s_r.hph) == PH_FRONT)
    else $error("line pulse not after a finished line");
  vsync_top_a: assert property (
    frame_start |-> s_r.vph == PH_SYNC && s_r.vcnt == 16'h0000
    && s_r.cur[0] == 7'h00)
    else $error("vertical sync without restart at top");
  ac_frame_a: assert property (
    s_r.ctrl[`CTRL_ACBFRM] && !tft && $stable(s_r.ctrl)
    ##0 frame_start |-> $changed(ac_bias_toggle_out))
    else $error("ac bias did not toggle at frame start");
  de_window_a: assert property (
    en && tft && $past(en) && $past(tft)
    |-> data_enable_out == (s_r.hph == PH_ACT && s_r.vph == PH_ACT))
    else $error("data enable outside active window");
  tft_16_gaps_a: assert property (
    data_enable_out && tft && bpp == BPP16 && $stable(s_r.ctrl)
    |-> video_data_out[18:16] == 3'h0 && video_data_out[9:8] == 2'h0
    && video_data_out[2:0] == 3'h0)
    else $error("unused 16 bpp data bits driven");
  pack_low_a: assert property (
    $past(act_slot) && tft && bpp == BPP24 && $stable(s_r.ctrl)
    && !s_r.ctrl[`CTRL_PACK24]
    |-> video_data_out == $past(g_win[0].w0[23:0]))
    else $error("24 bpp low packing wrong");
  pack_high_a: assert property (
    $past(act_slot) && tft && bpp == BPP24 && $stable(s_r.ctrl)
    && s_r.ctrl[`CTRL_PACK24]
    |-> video_data_out == $past(g_win[0].w0[31:8]))
    else $error("24 bpp high packing wrong");
  mem_order_a: assert property (
    s_r.req && mem_ack_in && !s_r.drop && !restart && !s_r.req_s
    |=> s_r.ptr[0] == $past(mem_addr_out) + `WORD_BYTES)
    else $error("frame buffer address not ascending");
  under_set_a: assert property (
    under_ev |=> s_r.under)
    else $error("underrun flag lost");

endmodule : lcd_pixel_format_timing

// *** verif/panel_model.sv ***
// Panel side model: samples data and data enable at each pixel clock rise, and sync and bias edges on every clk_in.
// Assumes the pixel clock is far slower than clk_in, so its edges are
// found by sampling it with clk_in, as a real driver latches on PIXEL_CLOCK.
`timescale 1ns/1ps

module panel_model (
  // Clock and control.
  input  wire logic        clk_in,
  input  wire logic        clr_in,
  input  wire logic [15:0] pattern_in,
  // Panel pins.
  input  wire logic [23:0] vd_in,
  input  wire logic        pclk_in,
  input  wire logic        vs_in,
  input  wire logic        hs_in,
  input  wire logic        lp_in,
  input  wire logic        de_in,
  input  wire logic        ac_in,
  // Observations.
  output logic      [23:0] de_vd_out,
  output logic      [15:0] period_out,
  output logic             hi_used_out,
  output logic      [5:0]  seen_out
);
  logic        pclk_q, vs_q, hs_q, lp_q, ac_q;
  logic [15:0] cnt;
  logic [31:0] win;
  logic [31:0] w;

  assign w = {win[23:0], vd_in[7:0]};

  always @(posedge clk_in) begin
    {pclk_q, vs_q, hs_q, lp_q, ac_q} <= {pclk_in, vs_in, hs_in, lp_in, ac_in};
    cnt <= cnt + 16'h1;
    if (clr_in) begin
      {win, hi_used_out, seen_out, period_out} <= '0;
      de_vd_out <= '0;
    end else begin
      // The driver shifts data in on the rising edge only.
      if (pclk_in && !pclk_q) begin
        period_out <= cnt;
        cnt <= 16'h1;
        win <= w;
        if (de_in) de_vd_out <= vd_in;
        if (vd_in[7:4] != 4'h0) hi_used_out <= 1'b1;
        if (w[15:0] == pattern_in) seen_out[4] <= 1'b1;
        if ({w[27:24], w[19:16], w[11:8], w[3:0]} == pattern_in)
          seen_out[5] <= 1'b1;
      end
      if (vs_in && !vs_q) seen_out[0] <= 1'b1;
      if (hs_in && !hs_q) seen_out[1] <= 1'b1;
      if (lp_in && !lp_q) seen_out[2] <= 1'b1;
      if (ac_in != ac_q) seen_out[3] <= 1'b1;
    end
  end
endmodule : panel_model

// *** verif/tb_top.sv ***
// Self-checking bench for the LCD pixel format and timing block.
// Assumes a same-clock memory that answers each fetch one cycle late.
`timescale 1ns/1ps
`include "lcd_timing_consts.svh"

module tb_top;
  logic        clk_in, nrst_in, reg_wr_in, reg_rd_in, mem_ack_in, clr;
  logic [7:0]  reg_addr_in;
  logic [31:0] reg_wdata_in, mem_data_in, reg_rdata_out, mem_addr_out;
  logic [23:0] video_data_out, de_vd;
  logic        mem_req_out, pixel_clock_out, vsync_out, hsync_out;
  logic        line_pulse_out, data_enable_out, line_end_pulse_out;
  logic        ac_bias_toggle_out, hi_used, le_seen;
  logic [15:0] period, pattern;
  logic [5:0]  seen;
  int          errors, tests_run;
  // Single4 mono, then single8 mono, gray4, gray16, 256, 4096, dual4,
  // and single8 mono with the bias toggled once per frame.
  logic [31:0] stn_mode [8] = '{32'h0001_0005, 32'h0001_0009,
    32'h0001_0019, 32'h0001_0029, 32'h0001_0039, 32'h0001_0049,
    32'h0001_0001, 32'h0001_2009};
  logic [15:0] stn_pat [8] = '{16'hA5C3, 16'hA5C3, 16'hC900, 16'hA0A0,
    16'h9409, 16'hA0A0, 16'hAA55, 16'hA5C3};

  lcd_pixel_format_timing i_lcd_pixel_format_timing (
    .clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .mem_req_out(mem_req_out), .mem_addr_out(mem_addr_out),
    .mem_ack_in(mem_ack_in), .mem_data_in(mem_data_in),
    .video_data_out(video_data_out), .pixel_clock_out(pixel_clock_out),
    .vsync_out(vsync_out), .hsync_out(hsync_out),
    .line_pulse_out(line_pulse_out), .data_enable_out(data_enable_out),
    .line_end_pulse_out(line_end_pulse_out),
    .ac_bias_toggle_out(ac_bias_toggle_out));

  panel_model i_panel_model (
    .clk_in(clk_in), .clr_in(clr), .pattern_in(pattern),
    .vd_in(video_data_out), .pclk_in(pixel_clock_out), .vs_in(vsync_out),
    .hs_in(hsync_out), .lp_in(line_pulse_out), .de_in(data_enable_out),
    .ac_in(ac_bias_toggle_out), .de_vd_out(de_vd), .period_out(period),
    .hi_used_out(hi_used), .seen_out(seen));

  always #50 clk_in = ~clk_in;

  // Line end is a one slot pulse, so it is caught here between checks.
  always @(posedge clk_in) begin
    if (clr) le_seen <= 1'b0;
    else if (line_end_pulse_out) le_seen <= 1'b1;
  end

  // Fetched words carry their address low half, so order is visible.
  always @(posedge clk_in) begin
    mem_ack_in <= mem_req_out && !mem_ack_in;
    mem_data_in <= 32'hA5C3_0000 | {16'h0, mem_addr_out[15:0]};
  end

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    @(posedge clk_in);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk("read data", exp, reg_rdata_out);
    @(posedge clk_in);
  endtask : reg_rd

  task automatic t_idle;
    chk("pins idle", 32'h0, {1'b0, video_data_out, pixel_clock_out,
        vsync_out, hsync_out, line_pulse_out, data_enable_out,
        line_end_pulse_out, ac_bias_toggle_out});
  endtask : t_idle

  task automatic run(input logic [31:0] size, input logic [31:0] ctrl,
                     input logic [15:0] pat);
    reg_wr(`OFS_CTRL, 32'h0);
    reg_wr(`OFS_SIZE, size);
    reg_wr(`OFS_UPPER, 32'h0000_0100);
    reg_wr(`OFS_LOWER, 32'h0000_0200);
    reg_wr(`OFS_HTIME, 32'h0);
    reg_wr(`OFS_VTIME, 32'h0);
    reg_wr(`OFS_ACB, 32'h1);
    reg_wr(`OFS_CTRL, ctrl);
    pattern <= pat;
    clr <= 1'b1;
    @(posedge clk_in);
    clr <= 1'b0;
    repeat (1000) @(posedge clk_in);
  endtask : run

  task automatic t_tft(input logic pack);
    run(32'h0001_0003, 32'h0001_0283 | {21'h0, pack, 10'h0}, 16'h0);
    chk("pixel period", 32'h4, {16'h0, period});
    chk("syncs seen", 32'h3, {30'h0, seen[1:0]});
    chk("line end seen", 32'h1, {31'h0, le_seen});
    if (pack) chk("high pixel", 32'h00A5_C301, {8'h0, de_vd});
    else chk("low pixel", 32'hC301, {16'h0, de_vd[23:8]});
  endtask : t_tft

  // At 16 bpp the colour fields leave fixed gaps on the data pins.
  task automatic t_tft16;
    run(32'h0001_0003, 32'h0001_0203, 16'h0);
    chk("16 bpp gaps", 32'h0, {8'h0, de_vd & 24'h07_0307});
    chk("16 bpp line end", 32'h1, {31'h0, le_seen});
  endtask : t_tft16

  task automatic t_stn;
    for (int i = 0; i < 8; i++) begin
      run(32'h0001_001F, stn_mode[i], stn_pat[i]);
      chk("line and bias", 32'h3, {30'h0, seen[3:2]});
      if (i == 0) begin
        chk("upper nibble", 32'h0, {31'h0, hi_used});
        chk("nibble order", 32'h1, {31'h0, seen[5]});
      end else if (i == 4) begin
        chk("colour bits", 32'h1, {31'h0, seen[4]});
      end else if (i == 6) begin
        chk("dual halves", 32'h1, {31'h0, seen[4]});
      end else begin
        chk("bytes", 32'h1, {31'h0, seen[4]});
      end
    end
  endtask : t_stn

  task automatic results;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  initial begin
    #(40000 * 100);
    errors++;
    results;
  end

  initial begin
    {clk_in, nrst_in, reg_wr_in, reg_rd_in, clr} = '0;
    {reg_addr_in, reg_wdata_in, pattern, errors, tests_run} = '0;
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    t_idle;
    reg_rd(8'h40, 32'h0);
    reg_wr(`OFS_CTRL, 32'hFFFF_FFFE);
    reg_rd(`OFS_CTRL, 32'hFFFF_FFFE & `MASK_CTRL);
    t_tft(1'b0);
    t_tft(1'b1);
    t_tft16;
    t_stn;
    reg_wr(`OFS_CTRL, 32'h0);
    repeat (2) @(posedge clk_in);
    t_idle;
    results;
  end
endmodule : tb_top
